/* File: logic/acp_pad_cfg_regs.sv */
/*
 * Pad configuration bank for the audio clock pins: four bit-clock
 * inputs, four bit-clock outputs and four frame-clock inputs, each
 * with pull-down, slew and drive fields fed straight to the pad cell.
 * Twelve 16-bit registers sit at consecutive word indices; the byte
 * address on the bus is four times the index, and anything outside
 * the twelve, or not word aligned, answers with an error.
 * Each transfer takes one wait state before PREADY rises.
 * Assumes an APB master on CLK and pad cells that take static levels.
 * Assumes PSTRB lanes 0 and 1 select the stored half of each word;
 * lanes 2 and 3 and the upper half of PWDATA are ignored.
 */
`default_nettype none
module acp_pad_cfg_regs
(
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [acp_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [acp_pkg::DATA_W-1:0]  PWDATA,
  input  wire logic [3:0]                  PSTRB,
  output var  logic                        PREADY,
  output var  logic [acp_pkg::DATA_W-1:0]  PRDATA,
  output var  logic                        PSLVERR,
  output var  logic                        BIT_CLK_IN0_PULL_DN,
  output var  acp_pkg::acp_slew_e          BIT_CLK_IN0_SLEW,
  output var  acp_pkg::acp_drive_e         BIT_CLK_IN0_DRIVE,
  output var  logic                        BIT_CLK_IN1_PULL_DN,
  output var  acp_pkg::acp_slew_e          BIT_CLK_IN1_SLEW,
  output var  acp_pkg::acp_drive_e         BIT_CLK_IN1_DRIVE,
  output var  logic                        BIT_CLK_IN2_PULL_DN,
  output var  acp_pkg::acp_slew_e          BIT_CLK_IN2_SLEW,
  output var  acp_pkg::acp_drive_e         BIT_CLK_IN2_DRIVE,
  output var  logic                        BIT_CLK_IN3_PULL_DN,
  output var  acp_pkg::acp_slew_e          BIT_CLK_IN3_SLEW,
  output var  acp_pkg::acp_drive_e         BIT_CLK_IN3_DRIVE,
  output var  logic                        BIT_CLK_OUT0_PULL_DN,
  output var  acp_pkg::acp_slew_e          BIT_CLK_OUT0_SLEW,
  output var  acp_pkg::acp_drive_e         BIT_CLK_OUT0_DRIVE,
  output var  logic                        BIT_CLK_OUT1_PULL_DN,
  output var  acp_pkg::acp_slew_e          BIT_CLK_OUT1_SLEW,
  output var  acp_pkg::acp_drive_e         BIT_CLK_OUT1_DRIVE,
  output var  logic                        BIT_CLK_OUT2_PULL_DN,
  output var  acp_pkg::acp_slew_e          BIT_CLK_OUT2_SLEW,
  output var  acp_pkg::acp_drive_e         BIT_CLK_OUT2_DRIVE,
  output var  logic                        BIT_CLK_OUT3_PULL_DN,
  output var  acp_pkg::acp_slew_e          BIT_CLK_OUT3_SLEW,
  output var  acp_pkg::acp_drive_e         BIT_CLK_OUT3_DRIVE,
  output var  logic                        FRAME_CLK_IN0_PULL_DN,
  output var  acp_pkg::acp_slew_e          FRAME_CLK_IN0_SLEW,
  output var  acp_pkg::acp_drive_e         FRAME_CLK_IN0_DRIVE,
  output var  logic                        FRAME_CLK_IN1_PULL_DN,
  output var  acp_pkg::acp_slew_e          FRAME_CLK_IN1_SLEW,
  output var  acp_pkg::acp_drive_e         FRAME_CLK_IN1_DRIVE,
  output var  logic                        FRAME_CLK_IN2_PULL_DN,
  output var  acp_pkg::acp_slew_e          FRAME_CLK_IN2_SLEW,
  output var  acp_pkg::acp_drive_e         FRAME_CLK_IN2_DRIVE,
  output var  logic                        FRAME_CLK_IN3_PULL_DN,
  output var  acp_pkg::acp_slew_e          FRAME_CLK_IN3_SLEW,
  output var  acp_pkg::acp_drive_e         FRAME_CLK_IN3_DRIVE
);
  import acp_pkg::*;

  // Pin groups: four consecutive indices each, counted from the first
  localparam int unsigned OUT_BASE   = int'(IDX_BIT_CLOCK_OUT0 - IDX_BIT_CLOCK_IN0);
  localparam int unsigned FRAME_BASE = int'(IDX_FRAME_CLOCK_IN0 - IDX_BIT_CLOCK_IN0);
  localparam int unsigned GROUP_PINS = OUT_BASE;

  // Bus answer state: one wait state, then a registered answer
  typedef struct packed
  {
    logic              ready;
    logic              slverr;
    logic [DATA_W-1:0] rdata;
  } acp_bus_s;

  acp_bus_s st_r;
  acp_bus_s st_nxt;

  logic [IDX_W-1:0]    idx;
  logic [NUM_PADS-1:0] hit_vec;
  logic [NUM_PADS-1:0] wr_vec;
  logic [REG_W-1:0]    rd_word;
  logic                aligned;
  logic                upper_zero;
  logic                hit;
  logic                access;
  logic                start;
  logic                complete;
  logic                rd_start;
  logic                wr_done;
  logic [REG_W-1:0]    pad_q     [NUM_PADS];
  logic                pull_q    [NUM_PADS];
  acp_slew_e           slew_q    [NUM_PADS];
  acp_drive_e          drive_q   [NUM_PADS];

  // Word index from the byte address; low two bits must be zero
  assign idx        = PADDR[IDX_W+BYTE_SHIFT-1:BYTE_SHIFT];
  assign aligned    = (PADDR[BYTE_SHIFT-1:0] == 2'h0);
  assign upper_zero = (PADDR[ADDR_W-1:IDX_W+BYTE_SHIFT] == '0);

  // Bit-clock input selects, one per index
  assign hit_vec[0]  = (idx == IDX_BIT_CLOCK_IN0);
  assign hit_vec[1]  = (idx == IDX_BIT_CLOCK_IN1);
  assign hit_vec[2]  = (idx == IDX_BIT_CLOCK_IN2);
  assign hit_vec[3]  = (idx == IDX_BIT_CLOCK_IN3);

  // Bit-clock output selects
  assign hit_vec[4]  = (idx == IDX_BIT_CLOCK_OUT0);
  assign hit_vec[5]  = (idx == IDX_BIT_CLOCK_OUT1);
  assign hit_vec[6]  = (idx == IDX_BIT_CLOCK_OUT2);
  assign hit_vec[7]  = (idx == IDX_BIT_CLOCK_OUT3);

  // Frame-clock input selects
  assign hit_vec[8]  = (idx == IDX_FRAME_CLOCK_IN0);
  assign hit_vec[9]  = (idx == IDX_FRAME_CLOCK_IN1);
  assign hit_vec[10] = (idx == IDX_FRAME_CLOCK_IN2);
  assign hit_vec[11] = (idx == IDX_FRAME_CLOCK_IN3);

  // Mapped only when aligned, upper bits clear and one select set
  assign hit = aligned
             && upper_zero
             && (|hit_vec);

  // Access phase, its first cycle, and the edge at which the master sees PREADY
  assign access   = PSEL && PENABLE;
  assign start    = access && !st_r.ready;
  assign complete = access && st_r.ready;

  // A mapped read is captured in the first access cycle
  assign rd_start = start && !PWRITE && hit;

  // Write lands only at the completing edge of a mapped write
  assign wr_done = complete && PWRITE && hit;
  assign wr_vec  = wr_done ? hit_vec : '0;

  // Bit-clock input pins 0 to 3, one register each
  for (genvar i = 0; i < GROUP_PINS; i++)
  begin : g_bit_in
    acp_pad_reg
    #(
      .RESET_VAL (PAD_RESET)
    )
    u_reg
    (
      .clk     (CLK),
      .rst_n   (RST_N),
      .wr_en   (wr_vec[i]),
      .byte_en (PSTRB[1:0]),
      .wdata   (PWDATA[REG_W-1:0]),
      .value   (pad_q[i])
    );

    // Field split toward the pad cell
    assign pull_q[i]  = pad_q[i][PULL_BIT];
    assign slew_q[i]  = acp_slew_e'(pad_q[i][SLEW_HI:SLEW_LO]);
    assign drive_q[i] = acp_drive_e'(pad_q[i][DRIVE_HI:DRIVE_LO]);
  end

  // Bit-clock output pins 0 to 3, next four indices
  for (genvar i = 0; i < GROUP_PINS; i++)
  begin : g_bit_out
    acp_pad_reg
    #(
      .RESET_VAL (PAD_RESET)
    )
    u_reg
    (
      .clk     (CLK),
      .rst_n   (RST_N),
      .wr_en   (wr_vec[OUT_BASE+i]),
      .byte_en (PSTRB[1:0]),
      .wdata   (PWDATA[REG_W-1:0]),
      .value   (pad_q[OUT_BASE+i])
    );

    // Field split toward the pad cell
    assign pull_q[OUT_BASE+i]  = pad_q[OUT_BASE+i][PULL_BIT];
    assign slew_q[OUT_BASE+i]  = acp_slew_e'(pad_q[OUT_BASE+i][SLEW_HI:SLEW_LO]);
    assign drive_q[OUT_BASE+i] = acp_drive_e'(pad_q[OUT_BASE+i][DRIVE_HI:DRIVE_LO]);
  end

  // Frame-clock input pins 0 to 3, last four indices
  for (genvar i = 0; i < GROUP_PINS; i++)
  begin : g_frame_in
    acp_pad_reg
    #(
      .RESET_VAL (PAD_RESET)
    )
    u_reg
    (
      .clk     (CLK),
      .rst_n   (RST_N),
      .wr_en   (wr_vec[FRAME_BASE+i]),
      .byte_en (PSTRB[1:0]),
      .wdata   (PWDATA[REG_W-1:0]),
      .value   (pad_q[FRAME_BASE+i])
    );

    // Field split toward the pad cell
    assign pull_q[FRAME_BASE+i]  = pad_q[FRAME_BASE+i][PULL_BIT];
    assign slew_q[FRAME_BASE+i]  = acp_slew_e'(pad_q[FRAME_BASE+i][SLEW_HI:SLEW_LO]);
    assign drive_q[FRAME_BASE+i] = acp_drive_e'(pad_q[FRAME_BASE+i][DRIVE_HI:DRIVE_LO]);
  end

  // Read word picked by index; zero when no register matches
  always_comb
  begin
    rd_word = '0;
    unique case (idx)
      // Bit-clock inputs
      IDX_BIT_CLOCK_IN0:   rd_word = pad_q[0];
      IDX_BIT_CLOCK_IN1:   rd_word = pad_q[1];
      IDX_BIT_CLOCK_IN2:   rd_word = pad_q[2];
      IDX_BIT_CLOCK_IN3:   rd_word = pad_q[3];
      // Bit-clock outputs
      IDX_BIT_CLOCK_OUT0:  rd_word = pad_q[4];
      IDX_BIT_CLOCK_OUT1:  rd_word = pad_q[5];
      IDX_BIT_CLOCK_OUT2:  rd_word = pad_q[6];
      IDX_BIT_CLOCK_OUT3:  rd_word = pad_q[7];
      // Frame-clock inputs
      IDX_FRAME_CLOCK_IN0: rd_word = pad_q[8];
      IDX_FRAME_CLOCK_IN1: rd_word = pad_q[9];
      IDX_FRAME_CLOCK_IN2: rd_word = pad_q[10];
      IDX_FRAME_CLOCK_IN3: rd_word = pad_q[11];
      default:             rd_word = '0;
    endcase
  end

  // Answer sequencing: ready rises in the second access cycle
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.ready  = start;
    st_nxt.slverr = 1'b0;
    if (start)
    begin
      // Unmapped or misaligned address answers with an error
      st_nxt.slverr = !hit;
      if (rd_start)
      begin
        st_nxt.rdata = {{(DATA_W-REG_W){1'b0}}, rd_word};
      end
      else
      begin
        st_nxt.rdata = '0;
      end
    end
  end

  // Bus answer register
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      st_r.ready  <= 1'b0;
      st_r.slverr <= 1'b0;
      st_r.rdata  <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Bus outputs straight from the answer register
  assign PREADY  = st_r.ready;
  assign PSLVERR = st_r.slverr;
  assign PRDATA  = st_r.rdata;

  // Bit-clock input pin 0
  assign BIT_CLK_IN0_PULL_DN   = pull_q[0];
  assign BIT_CLK_IN0_SLEW      = slew_q[0];
  assign BIT_CLK_IN0_DRIVE     = drive_q[0];

  // Bit-clock input pin 1
  assign BIT_CLK_IN1_PULL_DN   = pull_q[1];
  assign BIT_CLK_IN1_SLEW      = slew_q[1];
  assign BIT_CLK_IN1_DRIVE     = drive_q[1];

  // Bit-clock input pin 2
  assign BIT_CLK_IN2_PULL_DN   = pull_q[2];
  assign BIT_CLK_IN2_SLEW      = slew_q[2];
  assign BIT_CLK_IN2_DRIVE     = drive_q[2];

  // Bit-clock input pin 3
  assign BIT_CLK_IN3_PULL_DN   = pull_q[3];
  assign BIT_CLK_IN3_SLEW      = slew_q[3];
  assign BIT_CLK_IN3_DRIVE     = drive_q[3];

  // Bit-clock output pin 0
  assign BIT_CLK_OUT0_PULL_DN  = pull_q[4];
  assign BIT_CLK_OUT0_SLEW     = slew_q[4];
  assign BIT_CLK_OUT0_DRIVE    = drive_q[4];

  // Bit-clock output pin 1
  assign BIT_CLK_OUT1_PULL_DN  = pull_q[5];
  assign BIT_CLK_OUT1_SLEW     = slew_q[5];
  assign BIT_CLK_OUT1_DRIVE    = drive_q[5];

  // Bit-clock output pin 2
  assign BIT_CLK_OUT2_PULL_DN  = pull_q[6];
  assign BIT_CLK_OUT2_SLEW     = slew_q[6];
  assign BIT_CLK_OUT2_DRIVE    = drive_q[6];

  // Bit-clock output pin 3
  assign BIT_CLK_OUT3_PULL_DN  = pull_q[7];
  assign BIT_CLK_OUT3_SLEW     = slew_q[7];
  assign BIT_CLK_OUT3_DRIVE    = drive_q[7];

  // Frame-clock input pin 0, shared with multipurpose pin ten
  assign FRAME_CLK_IN0_PULL_DN = pull_q[8];
  assign FRAME_CLK_IN0_SLEW    = slew_q[8];
  assign FRAME_CLK_IN0_DRIVE   = drive_q[8];

  // Frame-clock input pin 1, shared with multipurpose pin eleven
  assign FRAME_CLK_IN1_PULL_DN = pull_q[9];
  assign FRAME_CLK_IN1_SLEW    = slew_q[9];
  assign FRAME_CLK_IN1_DRIVE   = drive_q[9];

  // Frame-clock input pin 2, shared with multipurpose pin twelve
  assign FRAME_CLK_IN2_PULL_DN = pull_q[10];
  assign FRAME_CLK_IN2_SLEW    = slew_q[10];
  assign FRAME_CLK_IN2_DRIVE   = drive_q[10];

  // Frame-clock input pin 3, shared with multipurpose pin thirteen
  assign FRAME_CLK_IN3_PULL_DN = pull_q[11];
  assign FRAME_CLK_IN3_SLEW    = slew_q[11];
  assign FRAME_CLK_IN3_DRIVE   = drive_q[11];
endmodule : acp_pad_cfg_regs
`default_nettype wire

/* File: logic/acp_pad_reg.sv */
/*
 * One 16-bit pad configuration register with byte-lane writes.
 * Assumes the caller qualifies wr_en with a completed bus write.
 */
`default_nettype none
module acp_pad_reg
#(
  parameter logic [15:0] RESET_VAL = acp_pkg::PAD_RESET
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [1:0]  byte_en,
  input  wire logic [15:0] wdata,
  output var  logic [15:0] value
);
  import acp_pkg::*;

  typedef struct packed
  {
    logic [15:0] value;
  } acp_reg_s;

  acp_reg_s st_r;
  acp_reg_s st_nxt;

  // Byte lanes merge into the stored word, reserved bits included
  always_comb
  begin
    st_nxt = st_r;
    if (wr_en && byte_en[0])
    begin
      st_nxt.value[7:0] = wdata[7:0];
    end
    if (wr_en && byte_en[1])
    begin
      st_nxt.value[15:8] = wdata[15:8];
    end
  end

  // Synchronous reset to the documented value
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r.value <= RESET_VAL;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign value = st_r.value;
endmodule : acp_pad_reg
`default_nettype wire

/* File: logic/acp_pkg.sv */
/*
 * Shared constants for the audio clock pad configuration bank:
 * register indices, field positions, reset value and code types.
 * Assumes the APB data path is 32 bits and each register one word.
 */
`default_nettype none
package acp_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned REG_W      = 16;
  localparam int unsigned IDX_W      = 16;
  localparam int unsigned BYTE_SHIFT = 2;
  localparam int unsigned NUM_PADS   = 12;
  localparam int unsigned SEL_W      = 4;

  // Register indices; byte address is index times four
  localparam logic [15:0] IDX_BIT_CLOCK_IN0    = 16'hf780;
  localparam logic [15:0] IDX_BIT_CLOCK_IN1    = 16'hf781;
  localparam logic [15:0] IDX_BIT_CLOCK_IN2    = 16'hf782;
  localparam logic [15:0] IDX_BIT_CLOCK_IN3    = 16'hf783;
  localparam logic [15:0] IDX_BIT_CLOCK_OUT0   = 16'hf784;
  localparam logic [15:0] IDX_BIT_CLOCK_OUT1   = 16'hf785;
  localparam logic [15:0] IDX_BIT_CLOCK_OUT2   = 16'hf786;
  localparam logic [15:0] IDX_BIT_CLOCK_OUT3   = 16'hf787;
  localparam logic [15:0] IDX_FRAME_CLOCK_IN0  = 16'hf788;
  localparam logic [15:0] IDX_FRAME_CLOCK_IN1  = 16'hf789;
  localparam logic [15:0] IDX_FRAME_CLOCK_IN2  = 16'hf78a;
  localparam logic [15:0] IDX_FRAME_CLOCK_IN3  = 16'hf78b;

  // Field positions inside a pad register
  localparam int unsigned PULL_BIT = 4;
  localparam int unsigned SLEW_HI  = 3;
  localparam int unsigned SLEW_LO  = 2;
  localparam int unsigned DRIVE_HI = 1;
  localparam int unsigned DRIVE_LO = 0;

  // Every pad register resets to pull-down on, fast slew, lowest drive
  localparam logic [15:0] PAD_RESET = 16'h0018;

  // Ascending slew and drive codes
  typedef enum logic [1:0] {SLEW_SLOWEST, SLEW_SLOW, SLEW_FAST, SLEW_FASTEST} acp_slew_e;
  typedef enum logic [1:0] {DRIVE_LOWEST, DRIVE_LOW, DRIVE_HIGH, DRIVE_HIGHEST} acp_drive_e;
endpackage : acp_pkg
`default_nettype wire

/* File: test/acp_pad_cfg_monitor.sv */
/*
 * Checker for the pad bank: APB answer timing, refusals and pad fields.
 * Assumes it is bound to acp_pad_cfg_regs and sees only its ports.
 */
`default_nettype none
module acp_pad_cfg_monitor
(
  input wire logic                       CLK,
  input wire logic                       RST_N,
  input wire logic                       PSEL,
  input wire logic                       PENABLE,
  input wire logic                       PWRITE,
  input wire logic [acp_pkg::ADDR_W-1:0] PADDR,
  input wire logic [acp_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0]                 PSTRB,
  input wire logic                       PREADY,
  input wire logic [acp_pkg::DATA_W-1:0] PRDATA,
  input wire logic                       PSLVERR,
  input wire logic                       BIT_CLK_IN0_PULL_DN,
  input wire acp_pkg::acp_slew_e         BIT_CLK_IN0_SLEW,
  input wire acp_pkg::acp_drive_e        BIT_CLK_IN0_DRIVE,
  input wire logic                       FRAME_CLK_IN3_PULL_DN,
  input wire acp_pkg::acp_slew_e         FRAME_CLK_IN3_SLEW,
  input wire acp_pkg::acp_drive_e        FRAME_CLK_IN3_DRIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  import acp_pkg::*;
  // Packed pad fields of the first and last pin, and bus decode
  logic [4:0] in0;
  logic [4:0] fr3;
  logic       acc;
  logic       bad;
  assign in0 = {BIT_CLK_IN0_PULL_DN, BIT_CLK_IN0_SLEW, BIT_CLK_IN0_DRIVE};
  assign fr3 = {FRAME_CLK_IN3_PULL_DN, FRAME_CLK_IN3_SLEW, FRAME_CLK_IN3_DRIVE};
  assign acc = PSEL && PENABLE;
  assign bad = PADDR[1:0] != 2'h0 || PADDR < 32'h0003de00 || PADDR > 32'h0003de2c;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Steps of a transfer
  sequence s_req;
    acc && !PREADY;
  endsequence
  sequence s_done(a);
    acc && PREADY && PWRITE && PSTRB[0] && PADDR == a;
  endsequence

  property p_answer; s_req |=> PREADY && acc; endproperty
  property p_pulse; PREADY |=> !PREADY; endproperty
  property p_wr_in0; s_done(32'h0003de00) |=> in0 == $past(PWDATA[4:0]); endproperty
  property p_wr_fr3; s_done(32'h0003de2c) |=> fr3 == $past(PWDATA[4:0]); endproperty
  property p_hold;
    $past(RST_N) && !$past(acc && PREADY && PWRITE) |-> $stable(in0) && $stable(fr3);
  endproperty
  property p_reset;
    @(posedge CLK) disable iff (1'b0)
    !RST_N |=> in0 == 5'h18 && fr3 == 5'h18 && !PREADY && PRDATA == 32'h0;
  endproperty
  property p_err; s_req and bad |=> PSLVERR && PRDATA == 32'h0; endproperty
  property p_read;
    acc && PREADY && !PWRITE && PADDR == 32'h0003de00 |-> PRDATA[4:0] == in0 && PRDATA[31:16] == 16'h0;
  endproperty
  property p_ok; acc && PREADY && !bad |-> !PSLVERR; endproperty

  a_answer: assert property (p_answer) else $error("no answer after access");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_wr_in0: assert property (p_wr_in0) else $error("first pad fields wrong");
  a_wr_fr3: assert property (p_wr_fr3) else $error("last pad fields wrong");
  a_hold: assert property (p_hold) else $error("pad changed without write");
  a_reset: assert property (p_reset) else $error("reset value wrong");
  a_err: assert property (p_err) else $error("refusal missing");
  a_read: assert property (p_read) else $error("read data wrong");
  a_ok: assert property (p_ok) else $error("mapped access refused");
endmodule : acp_pad_cfg_monitor

bind acp_pad_cfg_regs acp_pad_cfg_monitor i_acp_pad_cfg_monitor (.*);
`default_nettype wire

/* File: test/acp_pad_cfg_regs_bench.sv */
/*
 * Bench for the pad bank: reset values, random writes and reads, refusals.
 * Assumes the monitor file is compiled with it for the bind.
 */
`default_nettype none
module acp_pad_cfg_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import acp_pkg::*;
  logic        CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA;
  logic [3:0]  PSTRB = 4'h0;
  logic        PREADY, PSLVERR;
  logic        pl [12];
  logic [1:0]  sl [12], dr [12];
  logic [15:0] mdl [12];
  logic [31:0] st = 32'h00017283;
  int          n_errors = 0, cmp_count = 0;

  // Clock of 10 ns
  always #5 CLK = ~CLK;

  // Device, pad fields gathered by pin index
  acp_pad_cfg_regs i_acp_pad_cfg_regs
  (
    .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR),
    .BIT_CLK_IN0_PULL_DN(pl[0]), .BIT_CLK_IN0_SLEW(sl[0]), .BIT_CLK_IN0_DRIVE(dr[0]),
    .BIT_CLK_IN1_PULL_DN(pl[1]), .BIT_CLK_IN1_SLEW(sl[1]), .BIT_CLK_IN1_DRIVE(dr[1]),
    .BIT_CLK_IN2_PULL_DN(pl[2]), .BIT_CLK_IN2_SLEW(sl[2]), .BIT_CLK_IN2_DRIVE(dr[2]),
    .BIT_CLK_IN3_PULL_DN(pl[3]), .BIT_CLK_IN3_SLEW(sl[3]), .BIT_CLK_IN3_DRIVE(dr[3]),
    .BIT_CLK_OUT0_PULL_DN(pl[4]), .BIT_CLK_OUT0_SLEW(sl[4]), .BIT_CLK_OUT0_DRIVE(dr[4]),
    .BIT_CLK_OUT1_PULL_DN(pl[5]), .BIT_CLK_OUT1_SLEW(sl[5]), .BIT_CLK_OUT1_DRIVE(dr[5]),
    .BIT_CLK_OUT2_PULL_DN(pl[6]), .BIT_CLK_OUT2_SLEW(sl[6]), .BIT_CLK_OUT2_DRIVE(dr[6]),
    .BIT_CLK_OUT3_PULL_DN(pl[7]), .BIT_CLK_OUT3_SLEW(sl[7]), .BIT_CLK_OUT3_DRIVE(dr[7]),
    .FRAME_CLK_IN0_PULL_DN(pl[8]), .FRAME_CLK_IN0_SLEW(sl[8]), .FRAME_CLK_IN0_DRIVE(dr[8]),
    .FRAME_CLK_IN1_PULL_DN(pl[9]), .FRAME_CLK_IN1_SLEW(sl[9]), .FRAME_CLK_IN1_DRIVE(dr[9]),
    .FRAME_CLK_IN2_PULL_DN(pl[10]), .FRAME_CLK_IN2_SLEW(sl[10]), .FRAME_CLK_IN2_DRIVE(dr[10]),
    .FRAME_CLK_IN3_PULL_DN(pl[11]), .FRAME_CLK_IN3_SLEW(sl[11]), .FRAME_CLK_IN3_DRIVE(dr[11])
  );

  // Xorshift source
  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : xs

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer, then one idle cycle
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic er);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    PSTRB   <= s;
    @(posedge CLK);
    PENABLE <= 1'b1;
    while (PREADY !== 1'b1)
      @(posedge CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : xfer

  // Access pin i (12 unmapped, 13 misaligned) and check against the model
  task automatic op(input logic w, input int i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] a, rd;
    logic        er;
    a = (i == 13) ? 32'h0003de01 : {14'h0, IDX_BIT_CLOCK_IN0 + 16'(i), 2'h0};
    xfer(w, a, d, s, rd, er);
    chk("slverr", 32'(er), 32'(i > 11));
    if (i < 12 && w && s[0]) mdl[i][7:0] = d[7:0];
    if (i < 12 && w && s[1]) mdl[i][15:8] = d[15:8];
    if (!w) chk("rdata", rd, (i < 12) ? {16'h0, mdl[i]} : 32'h0);
    if (i < 12) chk("pad", {27'h0, pl[i], sl[i], dr[i]}, {27'h0, mdl[i][4:0]});
  endtask : op

  // Reset for six cycles, then read every register
  task automatic rst();
    RST_N <= 1'b0;
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    foreach (mdl[i]) mdl[i] = PAD_RESET;
    for (int i = 0; i < 12; i++) op(1'b0, i, 32'h0, 4'h0);
  endtask : rst

  // Verdict
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // Random writes with read-back, every slew and drive code in turn
  initial
  begin
    rst();
    for (int k = 0; k < 60; k++)
    begin
      logic [31:0] d;
      int          i;
      d = xs();
      d[3:0] = {2{k[1:0]}};
      i = int'(xs() % 14);
      op(1'b1, i, d, 4'(xs()) | 4'(k < 8));
      op(1'b0, i, 32'h0, 4'h0);
    end
    rst();
    stop_test();
  end

  // Watchdog, far beyond the few microseconds of traffic
  initial
  begin
    #50us;
    n_errors++;
    stop_test();
  end
endmodule : acp_pad_cfg_regs_bench
`default_nettype wire
